// *** hdl/buck_regulator_register_bank.sv ***
// Register bank of the step-down regulator with its serial access port
`timescale 1ns/1ps
module buck_regulator_register_bank #(
    parameter int SOFTSTART_US = 250,
    parameter logic [2:0] VENDOR_CODE = 3'h2, // Arbitrary value
    parameter logic [3:0] CHIP_TYPE = 4'h3, // Arbitrary value
    parameter logic [3:0] DIE_REVISION = 4'h1 // Arbitrary value
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control pins
    input wire logic en_pin,
    input wire logic voltage_select_pin,
    input wire logic mode_pin,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Regulator controls and status
    output logic regulator_run,
    output logic [regbank_pkg::CODE_MSB:0] target_code,
    output logic [20:0] vout_uv,
    output logic [15:0] ramp_rate_uv_us,
    output logic pwm_forced,
    output logic pulldown_on,
    output logic power_good_flag
);
    import regbank_pkg::*;

    localparam int SS_CYCLES = SOFTSTART_US * CLK_MHZ;
    localparam int SS_W = $clog2(SS_CYCLES + 1);
    localparam logic [SS_W-1:0] SS_LAST = SS_W'(SS_CYCLES - 1);

    regbank_bus_if bus ();

    logic [7:0] sp_low_reg, sp_low_next, sp_high_reg, sp_high_next;
    logic disch_reg, disch_next, rst_stat_reg, rst_stat_next;
    logic [2:0] slew_reg, slew_next;
    logic [1:0] mode_reg, mode_next;
    logic [SS_W-1:0] ss_cnt_reg, ss_cnt_next;
    logic run_reg, run_next, pwm_reg, pwm_next, pull_reg, pull_next, power_good_flag_reg, power_good_flag_next;
    logic [CODE_MSB:0] code_reg, code_next;
    logic [20:0] vout_reg, vout_next;
    logic [15:0] ramp_reg, ramp_next;
    logic soft_rst, rd_status;

    // ------------------------------------------------------------
    // Serial access
    // ------------------------------------------------------------
    serial_target_port port_u (
        .ref_clk(ref_clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    // Read view; reserved and trigger bits are forced low here, not stored
    function automatic logic [7:0] read_view(input logic [7:0] a);
        case (a)
            OFS_SP_LOW: read_view = sp_low_reg;
            OFS_SP_HIGH: read_view = sp_high_reg;
            OFS_CTRL: read_view = {disch_reg, slew_reg, 2'b00, mode_reg};
            OFS_ID1: read_view = {VENDOR_CODE, 1'b0, CHIP_TYPE};
            OFS_ID2: read_view = {4'h0, DIE_REVISION};
            OFS_STATUS: read_view = {power_good_flag_reg, 4'h0, rst_stat_reg, 2'b00};
            default: read_view = 8'h00;
        endcase
    endfunction

    assign bus.rdata = read_view(bus.addr);
    assign soft_rst = bus.wr_stb && bus.addr == OFS_CTRL && bus.wdata[CTRL_RST_BIT];
    assign rd_status = bus.rd_stb && bus.addr == OFS_STATUS;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Write decode; the reset trigger is checked last so its set beats the read clear
    always_comb begin
        sp_low_next = sp_low_reg;
        sp_high_next = sp_high_reg;
        disch_next = disch_reg;
        slew_next = slew_reg;
        mode_next = mode_reg;
        rst_stat_next = rst_stat_reg;
        if (rd_status) begin
            rst_stat_next = 1'b0;
        end
        if (soft_rst) begin
            sp_low_next = SP_LOW_RESET;
            sp_high_next = SP_HIGH_RESET;
            disch_next = CTRL_RESET[DISCH_BIT];
            slew_next = CTRL_RESET[SLEW_MSB:SLEW_LSB];
            mode_next = CTRL_RESET[MODE_MSB:0];
            rst_stat_next = 1'b1;
        end else if (bus.wr_stb) begin
            case (bus.addr)
                OFS_SP_LOW: sp_low_next = bus.wdata;
                OFS_SP_HIGH: sp_high_next = bus.wdata;
                OFS_CTRL: begin
                    disch_next = bus.wdata[DISCH_BIT];
                    slew_next = bus.wdata[SLEW_MSB:SLEW_LSB];
                    mode_next = bus.wdata[MODE_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Regulator controls
    // ------------------------------------------------------------
    // Selected bank drives code, enable and mode bit; outputs trail register writes by one cycle, except ramp rate, which follows slew in the same cycle
    always_comb begin
        code_next = voltage_select_pin ? sp_high_reg[CODE_MSB:0] : sp_low_reg[CODE_MSB:0];
        run_next = en_pin && (voltage_select_pin ? sp_high_reg[SP_EN_BIT]
                                                 : sp_low_reg[SP_EN_BIT]);
        vout_next = 21'(VOUT_REF_UV + STEP_UV * (int'(code_next) - CODE_ZERO));
        ramp_next = RATE_MAX_UV_US >> slew_next;
        pwm_next = mode_pin || (voltage_select_pin ? mode_reg[1] : mode_reg[0]);
        pull_next = disch_reg && !run_next;
        // Soft-start restarts from zero every time the regulator stops
        if (!run_next) begin
            ss_cnt_next = '0;
        end else if (ss_cnt_reg == SS_LAST) begin
            ss_cnt_next = ss_cnt_reg;
        end else begin
            ss_cnt_next = ss_cnt_reg + SS_W'(1);
        end
        power_good_flag_next = run_next && ss_cnt_reg == SS_LAST;
    end

    // State and output registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sp_low_reg <= SP_LOW_RESET;
            sp_high_reg <= SP_HIGH_RESET;
            disch_reg <= CTRL_RESET[DISCH_BIT];
            slew_reg <= CTRL_RESET[SLEW_MSB:SLEW_LSB];
            mode_reg <= CTRL_RESET[MODE_MSB:0];
            rst_stat_reg <= 1'b0;
            ss_cnt_reg <= '0;
            run_reg <= 1'b0;
            code_reg <= SP_LOW_RESET[CODE_MSB:0];
            vout_reg <= 21'h0_0000;
            ramp_reg <= RATE_MAX_UV_US >> CTRL_RESET[SLEW_MSB:SLEW_LSB];
            pwm_reg <= 1'b0;
            pull_reg <= CTRL_RESET[DISCH_BIT];
            power_good_flag_reg <= 1'b0;
        end else begin
            sp_low_reg <= sp_low_next;
            sp_high_reg <= sp_high_next;
            disch_reg <= disch_next;
            slew_reg <= slew_next;
            mode_reg <= mode_next;
            rst_stat_reg <= rst_stat_next;
            ss_cnt_reg <= ss_cnt_next;
            run_reg <= run_next;
            code_reg <= code_next;
            vout_reg <= vout_next;
            ramp_reg <= ramp_next;
            pwm_reg <= pwm_next;
            pull_reg <= pull_next;
            power_good_flag_reg <= power_good_flag_next;
        end
    end

    assign regulator_run = run_reg;
    assign target_code = code_reg;
    assign vout_uv = vout_reg;
    assign ramp_rate_uv_us = ramp_reg;
    assign pwm_forced = pwm_reg;
    assign pulldown_on = pull_reg;
    assign power_good_flag = power_good_flag_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_code_high: assert property (voltage_select_pin |=>
        code_reg == $past(sp_high_reg[CODE_MSB:0])) else $error("high bank not applied");
    chk_code_low: assert property (!voltage_select_pin |=>
        code_reg == $past(sp_low_reg[CODE_MSB:0])) else $error("low bank not applied");
    chk_enable_pin: assert property (!en_pin |=> !run_reg && !power_good_flag_reg)
        else $error("runs with enable pin low");
    chk_soft_enable: assert property (en_pin && voltage_select_pin &&
        !sp_high_reg[SP_EN_BIT] |=> !run_reg) else $error("soft enable ignored");
    chk_vout_code: assert property ($past(!reset) |->
        int'(vout_reg) == VOUT_REF_UV + STEP_UV * (int'(code_reg) - CODE_ZERO))
        else $error("output voltage not matching code");
    chk_pulldown_off: assert property ($past(!reset) |->
        pull_reg == ($past(disch_reg) && !run_reg)) else $error("pull-down wrong");
    chk_ramp_rate: assert property (ramp_reg == (RATE_MAX_UV_US >> slew_reg))
        else $error("ramp rate mismatch");
    chk_reserved_zero: assert property (bus.addr == OFS_CTRL |->
        bus.rdata[3:2] == 2'b00) else $error("reserved control bits nonzero");
    chk_ident_read: assert property (bus.addr == OFS_ID1 |->
        bus.rdata == {VENDOR_CODE, 1'b0, CHIP_TYPE}) else $error("ident one wrong");
    chk_reset_trigger: assert property (soft_rst |=> sp_low_reg == SP_LOW_RESET &&
        sp_high_reg == SP_HIGH_RESET && slew_reg == 3'h0 && rst_stat_reg)
        else $error("register reset not applied");
    chk_status_clear: assert property (rd_status && !soft_rst |=> !rst_stat_reg)
        else $error("reset flag not cleared by read");
    chk_power_good_flag_ready: assert property ($rose(power_good_flag_reg) |-> run_reg &&
        ss_cnt_reg == SS_LAST && $past(run_reg)) else $error("early power good");
    chk_ro_write: assert property (bus.wr_stb && bus.addr > OFS_CTRL && !bus.rd_stb
        |=> $stable(rst_stat_reg) && $stable(sp_low_reg)) else $error("read-only write took");
    chk_mode_pin: assert property (mode_pin |=> pwm_reg)
        else $error("mode pin did not force PWM");

    cov_soft_reset: cover property (soft_rst ##1 rst_stat_reg);
    cov_power_good: cover property ($rose(power_good_flag_reg));
    cov_bank_swap: cover property (run_reg && $changed(voltage_select_pin) ##1 run_reg);
    cov_status_read: cover property (rd_status && rst_stat_reg);
endmodule

// *** hdl/regbank_bus_if.sv ***
// Internal register access carrier between serial port and register bank
`timescale 1ns/1ps
interface regbank_bus_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// *** hdl/regbank_pkg.sv ***
// Constants shared by the regulator register bank and its serial port
package regbank_pkg;
    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SP_LOW = 8'h00;
    localparam logic [7:0] OFS_SP_HIGH = 8'h01;
    localparam logic [7:0] OFS_CTRL = 8'h02;
    localparam logic [7:0] OFS_ID1 = 8'h03;
    localparam logic [7:0] OFS_ID2 = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h05;
    localparam logic [7:0] SP_LOW_RESET = 8'hd4;
    localparam logic [7:0] SP_HIGH_RESET = 8'hcd;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SP_EN_BIT = 7;
    localparam int CODE_MSB = 6;
    localparam int DISCH_BIT = 7;
    localparam int SLEW_MSB = 6;
    localparam int SLEW_LSB = 4;
    localparam int CTRL_RST_BIT = 2;
    localparam int MODE_MSB = 1;
    localparam int STAT_POWER_GOOD_FLAG_BIT = 7;
    localparam int STAT_RST_BIT = 2;
    // ------------------------------------------------------------
    // Serial bus, voltage scale and timing
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h60;
    localparam int VOUT_REF_UV = 1000000;
    localparam int CODE_ZERO = 64;
    localparam int STEP_UV = 6250;
    localparam logic [15:0] RATE_MAX_UV_US = 16'hfa00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
endpackage

// *** hdl/serial_target_port.sv ***
// Two-wire serial target that turns bus frames into register strobes
`timescale 1ns/1ps
module serial_target_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register access
    regbank_bus_if.port bus
);
    import regbank_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_DEV = 7'h02, ST_REG = 7'h04, ST_WR = 7'h08,
        ST_RD = 7'h10, ST_ACK = 7'h20, ST_MACK = 7'h40
    } link_state_t;

    link_state_t state_reg, state_next, ret_reg, ret_next;
    logic scl_q_reg, sda_q_reg, oe_reg, oe_next, wr_reg, wr_next, rd_reg, rd_next;
    logic [7:0] shift_reg, shift_next, addr_reg, addr_next, wdata_reg, wdata_next;
    logic [3:0] cnt_reg, cnt_next;
    logic start, stop, rise, fall;

    // Bus conditions from the live pins against their previous samples
    assign start = scl_in && scl_q_reg && sda_q_reg && !sda_in;
    assign stop = scl_in && scl_q_reg && !sda_q_reg && sda_in;
    assign rise = scl_in && !scl_q_reg;
    assign fall = !scl_in && scl_q_reg;

    // Frame sequencing; the register pointer survives a repeated start
    always_comb begin
        state_next = state_reg;
        ret_next = ret_reg;
        oe_next = oe_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        wdata_next = wdata_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        addr_next = (wr_reg || rd_reg) ? addr_reg + 8'h01 : addr_reg;
        if (start) begin
            state_next = ST_DEV;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_DEV, ST_REG, ST_WR: begin
                    if (rise && cnt_reg != 4'h8) begin
                        shift_next = {shift_reg[6:0], sda_in};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        state_next = ST_ACK;
                        ret_next = ST_WR;
                        if (state_reg == ST_DEV) begin
                            // Foreign addresses drop back to idle without an ack
                            if (shift_reg[7:1] != TARGET_ADDR) begin
                                oe_next = 1'b0;
                                state_next = ST_IDLE;
                            end
                            ret_next = shift_reg[0] ? ST_RD : ST_REG;
                        end else if (state_reg == ST_REG) begin
                            addr_next = shift_reg;
                        end else begin
                            wr_next = 1'b1;
                            wdata_next = shift_reg;
                        end
                    end
                end
                ST_ACK: begin
                    if (fall) begin
                        oe_next = 1'b0;
                        state_next = ret_reg;
                        if (ret_reg == ST_RD) begin
                            shift_next = bus.rdata;
                            oe_next = !bus.rdata[7];
                            rd_next = 1'b1;
                            cnt_next = 4'h1;
                        end
                    end
                end
                ST_RD: begin
                    if (fall && cnt_reg == 4'h8) begin
                        oe_next = 1'b0;
                        state_next = ST_MACK;
                    end else if (fall) begin
                        oe_next = !shift_reg[6];
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                ST_MACK: begin
                    // Host ack asks for the next byte, a nack ends the read
                    if (rise) begin
                        state_next = sda_in ? ST_IDLE : ST_ACK;
                        ret_next = ST_RD;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // Port state registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            oe_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            shift_reg <= 8'h00;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            cnt_reg <= 4'h0;
            sda_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            ret_reg <= ret_next;
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            oe_reg <= oe_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            cnt_reg <= cnt_next;
            sda_out <= 1'b0;
        end
    end

    assign sda_oe = oe_reg;
    assign bus.wr_stb = wr_reg;
    assign bus.rd_stb = rd_reg;
    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
endmodule

// *** sim/serial_host.sv ***
// Two-wire bus host model that frames register accesses for the bank
`timescale 1ns/1ps
module serial_host (
    // Clock
    input wire logic ref_clk,
    // Bus lines, open drain: a released line reads high
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    // Both lines released while idle
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Line changes always land just after an edge, never on it
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Four cycles per clock phase keeps well above the sampler's minimum
    task automatic bit_cycle(input logic drv, output logic seen);
        sda_drv <= drv;
        w(4);
        scl <= 1'b1;
        w(2);
        seen = sda_wire;
        w(2);
        scl <= 1'b0;
    endtask
    // Start and repeated start share one shape: data falls with clock high
    task automatic start();
        sda_drv <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(4);
        sda_drv <= 1'b0;
        w(4);
        scl <= 1'b0;
    endtask
    // Stop: data rises with clock high, then both stay released
    task automatic stop();
        sda_drv <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(4);
        sda_drv <= 1'b1;
        w(4);
    endtask
    // Byte out, MSB first, then the target's acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, nak);
    endtask
    // Byte in; last byte gets a not-acknowledge so the target lets go
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, b[i]);
        end
        bit_cycle(last, s);
    endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the regulator register bank
`timescale 1ns/1ps
module tb;
    import regbank_pkg::*;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    localparam logic [2:0] VEND = 3'h2; // Arbitrary value, same as the design default
    localparam logic [3:0] CHIP = 4'h3; // Arbitrary value, same as the design default
    localparam logic [3:0] REV = 4'h1; // Arbitrary value, same as the design default
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic ref_clk, reset, en_pin, voltage_select_pin, mode_pin, scl, sda_drv;
    logic sda_out, sda_oe, regulator_run, pwm_forced, pulldown_on, power_good_flag;
    logic [6:0] target_code;
    logic [20:0] vout_uv;
    logic [15:0] ramp_rate_uv_us;
    logic [7:0] rd_val;
    logic nak;
    wire sda_wire = sda_drv & ~sda_oe;
    int fail_count = 0;
    int cmp_count = 0;
    row_t rows[7] = '{'{OFS_SP_LOW, 8'h55, 8'h55}, '{OFS_SP_HIGH, 8'hff, 8'hff},
        '{OFS_CTRL, 8'hfb, 8'hf3}, '{OFS_ID1, 8'hff, {VEND, 1'b0, CHIP}},
        '{OFS_ID2, 8'hff, {4'h0, REV}}, '{8'h07, 8'haa, 8'h00}, '{OFS_STATUS, 8'hff, 8'h00}};
    buck_regulator_register_bank i_dut (.ref_clk(ref_clk), .reset(reset), .en_pin(en_pin),
        .voltage_select_pin(voltage_select_pin), .mode_pin(mode_pin), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .regulator_run(regulator_run),
        .target_code(target_code), .vout_uv(vout_uv), .ramp_rate_uv_us(ramp_rate_uv_us),
        .pwm_forced(pwm_forced), .pulldown_on(pulldown_on), .power_good_flag(power_good_flag));
    serial_host i_host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.start();
        i_host.send_byte(8'hc0, nak);
        check("ack", nak, 1'b0);
        i_host.send_byte(a, nak);
        i_host.send_byte(d, nak);
        i_host.stop();
        i_host.w(4);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        i_host.start();
        i_host.send_byte(8'hc0, nak);
        i_host.send_byte(a, nak);
        i_host.start();
        i_host.send_byte(8'hc1, nak);
        i_host.recv_byte(1'b1, rd_val);
        i_host.stop();
        check(name, rd_val, exp);
    endtask
    task automatic results();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs about 35000 cycles, most of it soft-start; allow under twice that
    initial begin
        #600_000;
        fail_count++;
        results();
    end
    initial begin
        reset = 1'b1;
        en_pin = 1'b0;
        voltage_select_pin = 1'b0;
        mode_pin = 1'b0;
        i_host.w(12);
        reset <= 1'b0;
        i_host.w(3);
        // Power-on defaults at the outputs, regulator held off by the pin
        check("vout", vout_uv, 32'd1125000);
        check("ramp", ramp_rate_uv_us, 32'd64000);
        check("pulldown", pulldown_on, 1'b1);
        check("run", regulator_run, 1'b0);
        check("sda_out", sda_out, 1'b0);
        // Table of ordinary write-then-read cases
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e, "readback");
        end
        // Register reset trigger, status flag and clear-on-read
        wr(OFS_CTRL, 8'h04);
        rdchk(OFS_SP_LOW, 8'hd4, "sp_low");
        rdchk(OFS_SP_HIGH, 8'hcd, "sp_high");
        rdchk(OFS_CTRL, 8'h80, "ctrl");
        rdchk(OFS_STATUS, 8'h04, "status");
        rdchk(OFS_STATUS, 8'h00, "status");
        // Enable pin, soft-start and power good
        en_pin <= 1'b1;
        i_host.w(3);
        check("run", regulator_run, 1'b1);
        check("pulldown", pulldown_on, 1'b0);
        i_host.w(25010);
        check("power_good_flag", power_good_flag, 1'b1);
        rdchk(OFS_STATUS, 8'h80, "status");
        // Select pin switches to the second setpoint
        voltage_select_pin <= 1'b1;
        i_host.w(3);
        check("code", target_code, 7'h4d);
        check("vout", vout_uv, 32'd1081250);
        wr(OFS_SP_HIGH, 8'h4d);
        check("run", regulator_run, 1'b0);
        check("power_good_flag", power_good_flag, 1'b0);
        check("pulldown", pulldown_on, 1'b1);
        wr(OFS_SP_HIGH, 8'hcd);
        // Every ramp code; discharge cleared and mode bit 1 set meanwhile
        for (int n = 0; n < 8; n++) begin
            wr(OFS_CTRL, {1'b0, 3'(n), 4'b0010});
            check("ramp", ramp_rate_uv_us, 32'd64000 >> n);
            check("pwm", pwm_forced, 1'b1);
        end
        voltage_select_pin <= 1'b0;
        i_host.w(3);
        check("pwm", pwm_forced, 1'b0);
        mode_pin <= 1'b1;
        en_pin <= 1'b0;
        i_host.w(3);
        check("pwm", pwm_forced, 1'b1);
        check("pulldown", pulldown_on, 1'b0);
        // A foreign target address is never acknowledged
        i_host.start();
        i_host.send_byte(8'h60, nak);
        i_host.stop();
        check("nak", nak, 1'b1);
        // Mid-run reset brings the setpoint defaults back
        wr(OFS_SP_LOW, 8'h00);
        reset <= 1'b1;
        i_host.w(2);
        reset <= 1'b0;
        i_host.w(3);
        check("vout", vout_uv, 32'd1125000);
        rdchk(OFS_SP_LOW, 8'hd4, "sp_low");
        results();
    end
endmodule
